//--- cts_pkg.sv
// constants, register map and field layout shared by the scheduler/filter block
package cts_pkg;
  localparam int unsigned NUM_BUF = 3;
  localparam int unsigned BUF_BYTES = 13;
  localparam int unsigned MEM_DEPTH = 39;
  localparam int unsigned MEM_AW = 6;
  localparam int unsigned CNT_W = 9;
  // register byte offsets
  localparam logic [11:0] OFS_MCTL0 = 12'h000;
  localparam logic [11:0] OFS_MCTL1 = 12'h004;
  localparam logic [11:0] OFS_BTIM0 = 12'h008;
  localparam logic [11:0] OFS_BTIM1 = 12'h00C;
  localparam logic [11:0] OFS_RFLG = 12'h010;
  localparam logic [11:0] OFS_RIEN = 12'h014;
  localparam logic [11:0] OFS_TFLG = 12'h018;
  localparam logic [11:0] OFS_TCTL = 12'h01C;
  localparam logic [11:0] OFS_ACTL = 12'h020;
  localparam logic [11:0] OFS_RXERR = 12'h024;
  localparam logic [11:0] OFS_TXERR = 12'h028;
  localparam logic [11:0] OFS_PAT = 12'h040;
  localparam logic [11:0] OFS_MSK = 12'h060;
  localparam logic [11:0] OFS_TXBUF = 12'h100;
  localparam logic [3:0] RANK_SLOT = 4'hD;
  // receive flag register bit positions
  localparam int unsigned RF_WAKE = 7;
  localparam int unsigned RF_RWRN = 6;
  localparam int unsigned RF_TWRN = 5;
  localparam int unsigned RF_RPAS = 4;
  localparam int unsigned RF_TPAS = 3;
  localparam int unsigned RF_BOFF = 2;
  localparam int unsigned RF_OVR = 1;
  localparam int unsigned RF_RXF = 0;
  localparam logic [7:0] RF_ERR_MASK = 8'h7E;
  // transmit flag/control fields
  localparam int unsigned TF_ABAK_LSB = 4;
  localparam int unsigned TC_ABRQ_LSB = 4;
  localparam int unsigned AC_MODE_LSB = 4;
  // error counter thresholds
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
  localparam logic [8:0] BUSOFF_LIMIT = 9'h0FF;
  // reset values
  localparam logic SOFT_RST_INIT = 1'b1;
  localparam logic [2:0] TXE_INIT = 3'h7;
  localparam logic [7:0] BYTE_INIT = 8'h00;
  typedef enum logic [1:0]
  {
    FM_32 = 2'h0,
    FM_16 = 2'h1,
    FM_8 = 2'h2,
    FM_CLOSED = 2'h3
  } cts_fmode_t;
endpackage

//--- cts_buf_mem.sv
// transmit buffer byte store, one write port and two registered read ports
`timescale 1ns/1ps
module cts_buf_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = cts_pkg::MEM_DEPTH,
  parameter int unsigned AW = cts_pkg::MEM_AW
)(
  input wire logic pclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  output logic [WIDTH-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_b
);
  import cts_pkg::*;
  logic [WIDTH-1:0] mem [DEPTH];
  if (DEPTH < 1 || DEPTH > (1 << AW))
  begin : g_chk
    $error("cts_buf_mem: depth does not fit address width");
  end
  always_ff @(posedge pclk)
  begin
    if (ce)
    begin
      if (we && (32'(waddr) < DEPTH))
        mem[waddr] <= wdata;
      rdata_a <= (32'(raddr_a) < DEPTH) ? mem[raddr_a] : '0;
      rdata_b <= (32'(raddr_b) < DEPTH) ? mem[raddr_b] : '0;
    end
  end
endmodule

//--- cts_top.sv
// transmit scheduling, acceptance filter and interrupt flags of a CAN controller
// Overview of operation
// - three transmit buffers, each thirteen bytes of identifier, control and payload
// - each buffer has an eight bit rank register written by software
// - successful send sets the buffer empty flag and transmit interrupt if enabled
// - among scheduled buffers the numerically smallest rank is sent first
// - buffer selection reruns at every arbitration, including retries after errors
// - abort request on an idle buffer sets abort grant, empty flag and transmit interrupt if enabled
// - identifier bits compared to eight patterns, mask bits mark don't care
// - a match sets receive full and a three bit index of lowest hit
// - 32-bit mode: two filters over full identifier plus RTR, IDE, SRR
// - 16-bit mode: four filters, standard id plus RTR or top fourteen bits
// - 8-bit mode: eight filters over the first eight identifier bits
// - closed mode accepts no new frame; a frame already waiting in background still loads and sets receive full
// - receive full and interrupt set right after end of accepted frame
// - bus activity during sleep sets the wakeup flag
// - warning at 96, passive above 127, bus-off above 255, each own flag
// - interrupt pending while enabled flag set; write one clears unless cause stays
// - eleven maskable sources onto wakeup, error, receive and transmit outputs
// - error counters cannot be written by software
// - configuration registers writable only while soft reset bit is set
// - transmit output forced recessive while the CPU is in stop mode
// - transmit output low is dominant, high is recessive
`timescale 1ns/1ps
module cts_top #(
  parameter int unsigned NBUF = cts_pkg::NUM_BUF
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eng_arb,
  input wire logic eng_tx_ok,
  input wire logic eng_tx_err,
  input wire logic eng_tx_bit,
  input wire logic eng_rx_ok,
  input wire logic [28:0] eng_rx_id,
  input wire logic eng_rx_ide,
  input wire logic eng_rx_rtr,
  input wire logic eng_rx_srr,
  input wire logic [cts_pkg::CNT_W-1:0] eng_rec,
  input wire logic [cts_pkg::CNT_W-1:0] eng_tec,
  input wire logic eng_sleep,
  input wire logic [cts_pkg::MEM_AW-1:0] eng_rd_addr,
  output logic [7:0] eng_rd_data,
  output logic tx_start,
  output logic [1:0] tx_sel,
  output logic rx_fg_load,
  output logic soft_reset_bit,
  output logic [7:0] module_control_one,
  output logic [7:0] bit_timing_zero,
  output logic [7:0] bit_timing_one,
  input wire logic stop_mode,
  input wire logic can_rx_pin,
  output logic can_tx_output,
  output logic irq_wakeup,
  output logic irq_error,
  output logic irq_receive,
  output logic irq_transmit
);
  import cts_pkg::*;

  typedef struct packed {
    logic soft_rst;
    logic [7:0] mc1;
    logic [7:0] btr0;
    logic [7:0] btr1;
    logic [7:0] rflg;
    logic [7:0] rien;
    logic [2:0] tx_buffer_empty;
    logic [2:0] abak;
    logic [2:0] abrq;
    logic [2:0] txeie;
    logic [1:0] fmode;
    logic [2:0] hit;
    logic [7:0][7:0] pat;
    logic [7:0][7:0] msk;
    logic [2:0][7:0] rank;
    logic busy;
    logic [1:0] act;
    logic go;
    logic [1:0] sel;
    logic bg_full;
    logic [2:0] bg_hit;
    logic fg_load;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0] irq;
    logic txo;
    logic rx_s1;
    logic rx_s2;
  } cts_state_t;

  cts_state_t q;
  cts_state_t d;
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [MEM_AW-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [7:0] hits;
  logic [2:0] hit_low;
  logic [31:0] idw;

  if (NBUF != 3)
  begin : g_chk
    $error("cts_top: the scheduler serves exactly three buffers");
  end

  // byte address of a transmit buffer slot in the store
  function automatic logic [MEM_AW-1:0] buf_addr(input logic [11:0] a);
    return MEM_AW'(a[7:6] * 4'(BUF_BYTES) + a[5:2]);
  endfunction

  function automatic logic in_txbuf(input logic [11:0] a);
    return (a[11:8] == OFS_TXBUF[11:8]) && (a[7:6] != 2'h3) && (a[1:0] == 2'h0);
  endfunction

  // smallest rank among scheduled buffers; strict compare keeps lower index on ties
  function automatic logic [2:0] pick_buf(input logic [2:0][7:0] rk, input logic [2:0] ok);
    logic [7:0] best;
    logic [2:0] res;
    best = 8'hFF;
    res = 3'h0;
    for (int b = 0; b < 3; b++)
    begin
      if (ok[b] && (!res[2] || rk[b] < best))
      begin
        best = rk[b];
        res = {1'b1, 2'(b)};
      end
    end
    return res;
  endfunction

  // frame fields laid out as the four identifier bytes
  function automatic logic [31:0] id_word(input logic [28:0] id, input logic ide,
                                          input logic rtr, input logic srr);
    if (ide)
      return {id[28:18], srr, 1'b1, id[17:0], rtr};
    return {id[10:0], rtr, 1'b0, 19'h00000};
  endfunction

  // masked identifier compare
  // top n bits of w equal p wherever m is zero
  function automatic logic field_hit(input logic [31:0] w, input logic [31:0] p,
                                     input logic [31:0] m, input logic [5:0] n);
    return &(~(w ^ p) | m | (32'hFFFFFFFF >> n));
  endfunction

  function automatic logic [2:0] lowest(input logic [7:0] h);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (h[i])
        r = 3'(i);
    end
    return r;
  endfunction

  assign idw = id_word(eng_rx_id, eng_rx_ide, eng_rx_rtr, eng_rx_srr);
  assign hit_low = lowest(hits);

  always_comb
  begin
    hits = 8'h00;
    for (int f = 0; f < 8; f++)
    begin
      unique case (cts_fmode_t'(q.fmode))
        FM_32: if (f < 2)
          hits[f] = field_hit(idw, {q.pat[4*f], q.pat[4*f+1], q.pat[4*f+2], q.pat[4*f+3]},
                              {q.msk[4*f], q.msk[4*f+1], q.msk[4*f+2], q.msk[4*f+3]}, 6'd32);
        // four filters on the leading sixteen bits
        FM_16: if (f < 4)
          hits[f] = field_hit(idw, {q.pat[2*f], q.pat[2*f+1], 16'h0000},
                              {q.msk[2*f], q.msk[2*f+1], 16'h0000}, 6'd16);
        // eight filters on the leading byte
        FM_8: hits[f] = field_hit(idw, {q.pat[f], 24'h000000}, {q.msk[f], 24'h000000}, 6'd8);
        FM_CLOSED: hits[f] = 1'b0;
      endcase
    end
  end

  assign mem_raddr = buf_addr(paddr);

  always_comb
  begin
    logic wr;
    logic rd_now;
    logic mapped;
    logic [31:0] rv;
    logic [7:0] wb;
    logic [2:0] pk;
    logic [2:0] cond;
    wr = psel && penable && q.pready && pwrite;
    rd_now = psel && penable && !q.pready;
    wb = pwdata[7:0];
    pk = 3'h0;
    cond = 3'h0;
    d = q;
    d.go = 1'b0;
    d.fg_load = 1'b0;
    d.rx_s1 = can_rx_pin;
    d.rx_s2 = q.rx_s1;
    // one wait state: answer in the second access cycle
    d.pready = rd_now;
    mapped = 1'b1;
    rv = 32'h00000000;
    mem_we = 1'b0;
    mem_waddr = buf_addr(paddr);
    if (in_txbuf(paddr))
    begin
      if (paddr[5:2] == RANK_SLOT)
        rv = {24'h000000, q.rank[paddr[7:6]]};
      else if (paddr[5:2] < RANK_SLOT)
        rv = {24'h000000, mem_rdata};
      else
        mapped = 1'b0;
    end
    else if (paddr[11:5] == OFS_PAT[11:5])
      rv = {24'h000000, q.pat[paddr[4:2]]};
    else if (paddr[11:5] == OFS_MSK[11:5])
      rv = {24'h000000, q.msk[paddr[4:2]]};
    else
    begin
      unique case (paddr)
        OFS_MCTL0: rv = {31'h00000000, q.soft_rst};
        OFS_MCTL1: rv = {24'h000000, q.mc1};
        OFS_BTIM0: rv = {24'h000000, q.btr0};
        OFS_BTIM1: rv = {24'h000000, q.btr1};
        OFS_RFLG: rv = {24'h000000, q.rflg};
        OFS_RIEN: rv = {24'h000000, q.rien};
        OFS_TFLG: rv = {25'h0000000, q.abak, 1'b0, q.tx_buffer_empty};
        OFS_TCTL: rv = {25'h0000000, q.abrq, 1'b0, q.txeie};
        OFS_ACTL: rv = {26'h0000000, q.fmode, 1'b0, q.hit};
        OFS_RXERR: rv = {23'h000000, eng_rec};
        OFS_TXERR: rv = {23'h000000, eng_tec};
        default: mapped = 1'b0;
      endcase
    end
    if (rd_now)
    begin
      d.prdata = pwrite ? 32'h00000000 : rv;
      d.pslverr = !mapped;
    end
    if (wr && mapped)
    begin
      if (in_txbuf(paddr))
      begin
        if (paddr[5:2] == RANK_SLOT)
          d.rank[paddr[7:6]] = wb;
        else
          mem_we = 1'b1;
      end
      // configuration accepted only under soft reset
      else if (q.soft_rst && paddr[11:5] == OFS_PAT[11:5])
        d.pat[paddr[4:2]] = wb;
      else if (q.soft_rst && paddr[11:5] == OFS_MSK[11:5])
        d.msk[paddr[4:2]] = wb;
      else
      begin
        unique case (paddr)
          OFS_MCTL0: d.soft_rst = wb[0];
          OFS_MCTL1: if (q.soft_rst) d.mc1 = wb;
          OFS_BTIM0: if (q.soft_rst) d.btr0 = wb;
          OFS_BTIM1: if (q.soft_rst) d.btr1 = wb;
          OFS_RFLG: d.rflg = q.rflg & ~wb;
          OFS_RIEN: d.rien = wb;
          // clearing the empty flag schedules the buffer
          OFS_TFLG:
          begin
            d.tx_buffer_empty = q.tx_buffer_empty & ~wb[2:0];
            d.abak = q.abak & ~wb[2:0];
          end
          OFS_TCTL:
          begin
            d.txeie = wb[2:0];
            d.abrq = (q.abrq | wb[TC_ABRQ_LSB +: 3]) & ~q.tx_buffer_empty;
          end
          OFS_ACTL: if (q.soft_rst) d.fmode = wb[AC_MODE_LSB +: 2];
          default: d.rflg = d.rflg;
        endcase
      end
    end
    // threshold flags stay set while their cause persists
    cond[0] = (eng_rec >= WARN_LIMIT);
    cond[1] = (eng_tec >= WARN_LIMIT);
    cond[2] = (eng_tec > BUSOFF_LIMIT);
    d.rflg[RF_RWRN] = d.rflg[RF_RWRN] | cond[0];
    d.rflg[RF_TWRN] = d.rflg[RF_TWRN] | cond[1];
    d.rflg[RF_RPAS] = d.rflg[RF_RPAS] | (eng_rec > PASSIVE_LIMIT);
    d.rflg[RF_TPAS] = d.rflg[RF_TPAS] | (eng_tec > PASSIVE_LIMIT);
    d.rflg[RF_BOFF] = d.rflg[RF_BOFF] | cond[2];
    if (eng_sleep && !q.rx_s2)
      d.rflg[RF_WAKE] = 1'b1;
    if (q.soft_rst)
    begin
      d.busy = 1'b0;
    end
    else
    begin
      if (q.busy && eng_tx_ok)
      begin
        d.busy = 1'b0;
        d.tx_buffer_empty[q.act] = 1'b1;
        d.abak[q.act] = 1'b0;
        d.abrq[q.act] = 1'b0;
      end
      else if (q.busy && eng_tx_err)
        d.busy = 1'b0;
      // grant aborts for buffers not on the wire
      for (int b = 0; b < 3; b++)
      begin
        if (q.abrq[b] && !q.tx_buffer_empty[b] && !(q.busy && q.act == 2'(b)))
        begin
          d.tx_buffer_empty[b] = 1'b1;
          d.abak[b] = 1'b1;
          d.abrq[b] = 1'b0;
        end
      end
      pk = pick_buf(q.rank, ~q.tx_buffer_empty & ~q.abrq);
      if (eng_arb && !q.busy && pk[2])
      begin
        // smallest rank, lower index on ties
        d.busy = 1'b1;
        d.act = pk[1:0];
        d.sel = pk[1:0];
        d.go = 1'b1;
      end
      // accepted frame goes to foreground or waits in background
      if (eng_rx_ok && |hits)
      begin
        if (!q.rflg[RF_RXF])
        begin
          d.rflg[RF_RXF] = 1'b1;
          d.hit = lowest(hits);
          d.fg_load = 1'b1;
        end
        else if (!q.bg_full)
        begin
          d.bg_full = 1'b1;
          d.bg_hit = lowest(hits);
        end
        else
          d.rflg[RF_OVR] = 1'b1;
      end
      else if (q.bg_full && !q.rflg[RF_RXF])
      begin
        d.rflg[RF_RXF] = 1'b1;
        d.hit = q.bg_hit;
        d.bg_full = 1'b0;
        d.fg_load = 1'b1;
      end
    end
    // four outputs from eleven maskable sources
    d.irq[0] = q.rflg[RF_WAKE] & q.rien[RF_WAKE];
    d.irq[1] = |(q.rflg & q.rien & RF_ERR_MASK);
    d.irq[2] = q.rflg[RF_RXF] & q.rien[RF_RXF];
    d.irq[3] = |(q.tx_buffer_empty & q.txeie);
    d.txo = stop_mode | eng_tx_bit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.soft_rst <= SOFT_RST_INIT;
      q.tx_buffer_empty <= TXE_INIT;
      q.txo <= 1'b1;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
    end
    else if (ce)
      q <= d;
  end

  // message bytes of the three buffers
  cts_buf_mem #(.WIDTH(8), .DEPTH(MEM_DEPTH), .AW(MEM_AW)) u_mem (
    .pclk(pclk),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(pwdata[7:0]),
    .raddr_a(mem_raddr),
    .rdata_a(mem_rdata),
    .raddr_b(eng_rd_addr),
    .rdata_b(eng_rd_data)
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign tx_start = q.go;
  assign tx_sel = q.sel;
  assign rx_fg_load = q.fg_load;
  assign soft_reset_bit = q.soft_rst;
  assign module_control_one = q.mc1;
  assign bit_timing_zero = q.btr0;
  assign bit_timing_one = q.btr1;
  assign can_tx_output = q.txo;
  assign irq_wakeup = q.irq[0];
  assign irq_error = q.irq[1];
  assign irq_receive = q.irq[2];
  assign irq_transmit = q.irq[3];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence s_arb_win;
    eng_arb && !q.busy && !q.soft_rst && |(~q.tx_buffer_empty & ~q.abrq);
  endsequence

  a_pick_smallest: assert property (s_arb_win |=> tx_start &&
    (q.tx_buffer_empty[0] || $past(q.abrq[0]) || q.rank[tx_sel] <= q.rank[0]) &&
    (q.tx_buffer_empty[2] || $past(q.abrq[2]) || q.rank[tx_sel] <= q.rank[2]))
    else $error("scheduled buffer is not the smallest rank");
  a_tie_lower: assert property ((s_arb_win and (!q.tx_buffer_empty[1] && !q.abrq[1]
    && q.rank[1] == q.rank[2])) |=> tx_sel != 2'h2)
    else $error("tie not resolved to lower index");
  a_txe_on_done: assert property (q.busy && eng_tx_ok && !q.soft_rst
    |=> q.tx_buffer_empty[$past(q.act)] && !q.abak[$past(q.act)])
    else $error("empty flag not set after successful send");
  a_abort_grant: assert property (q.abrq[0] && !q.tx_buffer_empty[0] && !q.soft_rst
    && !(q.busy && q.act == 2'h0) |=> q.tx_buffer_empty[0] && q.abak[0] ##1 irq_transmit || !q.txeie[0])
    else $error("abort not granted on idle buffer");
  a_closed_quiet: assert property (q.fmode == FM_CLOSED && !q.bg_full
    |=> !rx_fg_load)
    else $error("closed filter loaded a frame");
  a_rxf_hit: assert property (eng_rx_ok && |hits && !q.rflg[RF_RXF] && !q.soft_rst
    |=> q.rflg[RF_RXF] && rx_fg_load && q.hit == $past(hit_low))
    else $error("receive full or hit index wrong");
  a_warn_flag: assert property (eng_tec >= WARN_LIMIT |=> q.rflg[RF_TWRN])
    else $error("transmit warning flag missing");
  a_cfg_lock: assert property (!q.soft_rst ##1 $stable(q.soft_rst)
    |-> $stable(q.fmode) && $stable(q.btr0) && $stable(q.pat))
    else $error("locked configuration changed");
  sequence s_apb_start;
    psel && !penable ##1 psel && penable;
  endsequence
  a_apb_wait: assert property (s_apb_start |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_err_irq: assert property (|(q.rflg & q.rien & RF_ERR_MASK) |=> irq_error)
    else $error("error interrupt not pending");
  a_stop_recessive: assert property (stop_mode |=> can_tx_output)
    else $error("transmit output not recessive in stop");
endmodule

//--- cts_eng_model.sv
// behavioural model of the protocol engine and bus line beside the block
`timescale 1ns/1ps
module cts_eng_model (
  input wire logic pclk,
  input wire logic tx_start,
  input wire logic [1:0] tx_sel,
  output logic eng_arb,
  output logic eng_tx_ok,
  output logic eng_tx_err,
  output logic eng_tx_bit,
  output logic eng_rx_ok,
  output logic [28:0] eng_rx_id,
  output logic eng_rx_ide,
  output logic eng_rx_rtr,
  output logic eng_rx_srr,
  output logic [8:0] eng_rec,
  output logic [8:0] eng_tec,
  output logic eng_sleep,
  output logic can_rx_pin
);
  initial
  begin
    {eng_arb, eng_tx_ok, eng_tx_err, eng_rx_ok, eng_sleep} = 5'h00;
    {eng_rx_ide, eng_rx_rtr, eng_rx_srr} = 3'h0;
    eng_tx_bit = 1'b1;
    can_rx_pin = 1'b1;
    eng_rx_id = 29'h0;
    eng_rec = 9'h000;
    eng_tec = 9'h000;
  end
  // returns 3 when no buffer was started
  task automatic arb(output logic [1:0] sel);
    int n;
    n = 0;
    @(posedge pclk) eng_arb <= 1'b1;
    @(posedge pclk) eng_arb <= 1'b0;
    while (tx_start !== 1'b1 && n < 8)
    begin
      @(posedge pclk);
      n++;
    end
    sel = (tx_start === 1'b1) ? tx_sel : 2'h3;
    // frame on the line starts dominant
    eng_tx_bit <= 1'b0;
  endtask
  task automatic done(input logic ok);
    @(posedge pclk);
    eng_tx_ok <= ok;
    eng_tx_err <= ~ok;
    @(posedge pclk);
    {eng_tx_ok, eng_tx_err} <= 2'h0;
    eng_tx_bit <= 1'b1;
  endtask
  task automatic errs(input logic [8:0] r, input logic [8:0] t);
    @(posedge pclk);
    eng_rec <= r;
    eng_tec <= t;
  endtask
  task automatic rx(input logic [28:0] id);
    @(posedge pclk);
    eng_rx_ok <= 1'b1;
    eng_rx_id <= id;
    @(posedge pclk);
    eng_rx_ok <= 1'b0;
    // identifier no longer valid after the pulse
    eng_rx_id <= ~id;
  endtask
  task automatic wake();
    @(posedge pclk) eng_sleep <= 1'b1;
    repeat (2) @(posedge pclk);
    can_rx_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    can_rx_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    eng_sleep <= 1'b0;
  endtask
endmodule

//--- can_tx_sched_filter_irq_tb_top.sv
// register level testbench of the scheduler, filter and interrupt block
`timescale 1ns/1ps
module can_tx_sched_filter_irq_tb_top;
  import cts_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, eng_arb, eng_tx_ok, eng_tx_err, eng_tx_bit, eng_rx_ok;
  logic eng_rx_ide, eng_rx_rtr, eng_rx_srr, eng_sleep, can_rx_pin, tx_start;
  logic can_tx_output, irq_wakeup, irq_error, irq_receive, irq_transmit, srb, fgl;
  logic [28:0] eng_rx_id;
  logic [8:0] eng_rec, eng_tec;
  logic [5:0] eng_rd_addr = 6'h00;
  logic [7:0] eng_rd_data, mc1;
  logic [1:0] tx_sel, sel;
  int n_errors = 0, n_compared = 0, cyc = 0;
  logic [3:0] hits [3] = '{4'h1, 4'h2, 4'h4};
  always #5 pclk = ~pclk;
  cts_top i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng_arb(eng_arb), .eng_tx_ok(eng_tx_ok), .eng_tx_err(eng_tx_err),
    .eng_tx_bit(eng_tx_bit), .eng_rx_ok(eng_rx_ok), .eng_rx_id(eng_rx_id),
    .eng_rx_ide(eng_rx_ide), .eng_rx_rtr(eng_rx_rtr), .eng_rx_srr(eng_rx_srr),
    .eng_rec(eng_rec), .eng_tec(eng_tec), .eng_sleep(eng_sleep), .eng_rd_addr(eng_rd_addr),
    .eng_rd_data(eng_rd_data), .tx_start(tx_start), .tx_sel(tx_sel), .rx_fg_load(fgl),
    .soft_reset_bit(srb), .module_control_one(mc1), .bit_timing_zero(), .bit_timing_one(),
    .stop_mode(stop_mode), .can_rx_pin(can_rx_pin), .can_tx_output(can_tx_output),
    .irq_wakeup(irq_wakeup), .irq_error(irq_error), .irq_receive(irq_receive),
    .irq_transmit(irq_transmit));
  cts_eng_model i_eng (.pclk(pclk), .tx_start(tx_start), .tx_sel(tx_sel), .eng_arb(eng_arb),
    .eng_tx_ok(eng_tx_ok), .eng_tx_err(eng_tx_err), .eng_tx_bit(eng_tx_bit),
    .eng_rx_ok(eng_rx_ok), .eng_rx_id(eng_rx_id), .eng_rx_ide(eng_rx_ide),
    .eng_rx_rtr(eng_rx_rtr), .eng_rx_srr(eng_rx_srr), .eng_rec(eng_rec), .eng_tec(eng_tec),
    .eng_sleep(eng_sleep), .can_rx_pin(can_rx_pin));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  initial
  begin
    wt(5);
    presetn <= 1'b1;
    rc(OFS_MCTL0, 32'h1);
    chk(srb, 1'b1);
    rc(OFS_TFLG, 32'h7);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wr(OFS_MCTL1, 32'h5A);
    wt(1);
    chk(mc1, 8'h5A);
    $display("test reset and map done");
    wr(OFS_TXBUF + 12'h034, 32'h05);
    wr(OFS_TXBUF + 12'h074, 32'h03);
    wr(OFS_TXBUF + 12'h0B4, 32'h03);
    wr(OFS_TXBUF + 12'h070, 32'hA5);
    wr(OFS_MCTL0, 32'h0);
    wr(OFS_MCTL1, 32'h33);
    rc(OFS_MCTL1, 32'h5A);
    @(posedge pclk) eng_rd_addr <= 6'd25;
    wt(2);
    chk(eng_rd_data, 8'hA5);
    wr(OFS_TCTL, 32'h7);
    // schedule all three buffers
    wr(OFS_TFLG, 32'h7);
    rc(OFS_TFLG, 32'h0);
    i_eng.arb(sel);
    chk(sel, 2'h1);
    i_eng.done(1'b0);
    // retry after an error
    i_eng.arb(sel);
    chk(sel, 2'h1);
    wt(2);
    chk(can_tx_output, 1'b0);
    @(posedge pclk) stop_mode <= 1'b1;
    wt(3);
    chk(can_tx_output, 1'b1);
    @(posedge pclk) stop_mode <= 1'b0;
    i_eng.done(1'b1);
    wt(3);
    chk(irq_transmit, 1'b1);
    rc(OFS_TFLG, 32'h2);
    wr(OFS_TCTL, 32'h11);
    rc(OFS_TFLG, 32'h13);
    chk(irq_transmit, 1'b1);
    i_eng.arb(sel);
    chk(sel, 2'h2);
    i_eng.done(1'b1);
    wt(3);
    rc(OFS_TFLG, 32'h17);
    $display("test transmit done");
    wr(OFS_RIEN, 32'h01);
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_MCTL0, 32'h1);
      wr(OFS_ACTL, 32'(m) << 4);
      for (int i = 0; i < 8; i++)
      begin
        wr(OFS_PAT + 12'(4 * i), 32'h0);
        wr(OFS_MSK + 12'(4 * i), (i < 4) ? 32'h0 : 32'hFF);
      end
      wr(OFS_MCTL0, 32'h0);
      i_eng.rx(29'h7FF);
      wt(1);
      chk(fgl, (m < 3) ? 1'b1 : 1'b0);
      wt(2);
      chk(irq_receive, (m < 3) ? 1'b1 : 1'b0);
      rc(OFS_RFLG, (m < 3) ? 32'h1 : 32'h0);
      if (m < 3)
        rc(OFS_ACTL, (32'(m) << 4) | 32'(hits[m]));
      wr(OFS_RFLG, 32'h1);
      rc(OFS_RFLG, 32'h0);
    end
    $display("test filter done");
    wr(OFS_RIEN, 32'hFE);
    i_eng.errs(9'd95, 9'd127);
    wt(3);
    rc(OFS_RFLG, 32'h20);
    wr(OFS_RFLG, 32'h20);
    i_eng.errs(9'd96, 9'd256);
    wt(3);
    wr(OFS_RFLG, 32'h6C);
    rc(OFS_RFLG, 32'h6C);
    chk(irq_error, 1'b1);
    wr(OFS_RXERR, 32'h0);
    rc(OFS_RXERR, 32'd96);
    i_eng.errs(9'd0, 9'd0);
    wt(2);
    wr(OFS_RFLG, 32'h6C);
    rc(OFS_RFLG, 32'h0);
    i_eng.wake();
    rc(OFS_RFLG, 32'h80);
    chk(irq_wakeup, 1'b1);
    wr(OFS_RFLG, 32'h80);
    wt(2);
    chk(irq_wakeup, 1'b0);
    $display("test error and wakeup done");
    end_of_test();
  end
endmodule
